// ===== rtl/ubg_uart.sv
// Serial port with baud tick generator, single-byte buffers, address marks.
// Operation
// - Enabling transmit interrupt while empty raises it.
// - First holding write drops pending transmit interrupt.
// - Parity select clears itself after each byte.
// - Early parity select set is cleared anyway.
// - Address mark raises line status interrupt cause.
// - Receiver watches input for start whenever idle.
// - Generator is 16-bit counter decrementing to one.
// - After one, reload divisor and pulse.
// - Bit rate is clock over sixteen times divisor.
// - Divisor resets to two.
// - Divisor byte write reloads and restarts count.
// - Divisor bytes reachable only with access bit.
// - Transmitter advances one bit per sixteen ticks.
`timescale 1ns/1ps
`default_nettype none
module ubg_uart
  import ubg_pkg::*;
#(
  parameter logic [7:0] BASE_ADDR = UBG_BASE0
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic rxd,
  output logic txd,
  output logic irq
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] divLo;
    logic [7:0] divHi;
    logic divLoad;
    logic [7:0] lctl;
    logic [7:0] ier;
    logic [7:0] thr;
    logic thrFull;
    ubg_ser_e txState;
    logic [3:0] txTick;
    logic [3:0] txBit;
    logic [8:0] txSh;
    logic txPen;
    logic txd;
    logic txIrq;
    logic txIrqTc;
    logic rxS1;
    logic rxS2;
    ubg_ser_e rxState;
    logic [3:0] rxTick;
    logic [3:0] rxBit;
    logic [8:0] rxSh;
    logic [7:0] rbr;
    logic dr;
    logic oe;
    logic pe;
    logic fe;
    logic [7:0] rdata;
  } ubg_st_s;
  ubg_st_s s_q, s_d;
  logic tick;
  logic [2:0] cause;
  logic pendAny;

  // True when the bus address selects the given register offset.
  function automatic logic hit(input logic [7:0] a, input logic [3:0] ofs);
    hit = (a == (BASE_ADDR | {4'h0, ofs}));
  endfunction

  // ----------------------------------------------------------------------
  // Baud tick generator
  // ----------------------------------------------------------------------
  // The divisor comes from flops, so a reload lands one cycle after the
  // bus write; the count restarts from the full new divisor.
  ubg_baud_tick u_tick (
    .clk(clk),
    .reset(reset),
    .divisor({s_q.divHi, s_q.divLo}),
    .load(s_q.divLoad),
    .tick(tick)
  );

  // ----------------------------------------------------------------------
  // Interrupt cause, highest priority first
  // ----------------------------------------------------------------------
  always_comb begin
    cause = 3'h0;
    pendAny = 1'b1;
    if (s_q.ier[IE_LSIE] && (s_q.pe || s_q.oe || s_q.fe)) begin
      cause = CAUSE_LS;
    end else if (s_q.ier[IE_RIE] && s_q.dr) begin
      cause = CAUSE_RX;
    end else if (s_q.txIrq && s_q.ier[s_q.txIrqTc ? IE_TCIE : IE_TIE]) begin
      cause = s_q.txIrqTc ? CAUSE_TC : CAUSE_HOLDING_EMPTY;
    end else begin
      pendAny = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Next state: bus, transmitter, receiver
  // ----------------------------------------------------------------------
  // A hardware event that sets a status flag beats a read that clears it.
  always_comb begin
    s_d = s_q;
    s_d.divLoad = 1'b0;
    s_d.rxS1 = rxd;
    s_d.rxS2 = s_q.rxS1;
    // Register writes; the access bit steers the shared addresses.
    if (wr) begin
      if (hit(addr, OFS_DATA) && s_q.lctl[LC_DLAB]) begin
        s_d.divLo = wdata;
        s_d.divLoad = 1'b1;
      end else if (hit(addr, OFS_DATA)) begin
        s_d.thr = wdata;
        s_d.thrFull = 1'b1;
        s_d.txIrq = 1'b0;
      end
      if (hit(addr, OFS_IER) && s_q.lctl[LC_DLAB]) begin
        s_d.divHi = wdata;
        s_d.divLoad = 1'b1;
      end else if (hit(addr, OFS_IER)) begin
        s_d.ier = wdata & IER_MASK;
        if (wdata[IE_TIE] && !s_q.ier[IE_TIE] && !s_q.thrFull) begin
          s_d.txIrq = 1'b1;
          s_d.txIrqTc = 1'b0;
        end
      end
      if (hit(addr, OFS_LCTL)) begin
        s_d.lctl = wdata;
      end
    end
    // Read side effects and registered read data.
    s_d.rdata = 8'h00;
    if (rd) begin
      if (hit(addr, OFS_DATA) && s_q.lctl[LC_DLAB]) begin
        s_d.rdata = s_q.divLo;
      end else if (hit(addr, OFS_DATA)) begin
        s_d.rdata = s_q.rbr;
        s_d.dr = 1'b0;
      end else if (hit(addr, OFS_IER)) begin
        s_d.rdata = s_q.lctl[LC_DLAB] ? s_q.divHi : s_q.ier;
      end else if (hit(addr, OFS_IIR)) begin
        s_d.rdata = {4'h0, cause, !pendAny};
      end else if (hit(addr, OFS_LCTL)) begin
        s_d.rdata = s_q.lctl;
      end else if (hit(addr, OFS_LSR)) begin
        s_d.rdata[LS_DR] = s_q.dr;
        s_d.rdata[LS_OE] = s_q.oe;
        s_d.rdata[LS_PE] = s_q.pe;
        s_d.rdata[LS_FE] = s_q.fe;
        s_d.rdata[LS_HOLD] = !s_q.thrFull;
        s_d.rdata[LS_TXIDLE] = !s_q.thrFull && s_q.txState == SER_IDLE;
        s_d.oe = 1'b0;
        s_d.pe = 1'b0;
        s_d.fe = 1'b0;
      end
    end
    // Transmitter: every frame bit holds for sixteen ticks.
    case (s_q.txState)
      SER_IDLE: begin
        // Loading on a tick makes the start bit a full sixteen ticks.
        if (s_q.thrFull && tick) begin
          s_d.txSh = {s_q.lctl[LC_ADR], s_q.thr};
          s_d.txPen = s_q.lctl[LC_PAR];
          // Only a new holding write in this cycle keeps the slot full.
          s_d.thrFull = wr && hit(addr, OFS_DATA) && !s_q.lctl[LC_DLAB];
          s_d.txTick = 4'h0;
          s_d.txState = SER_START;
          if (s_q.ier[IE_TIE] && !s_d.thrFull) begin
            s_d.txIrq = 1'b1;
            s_d.txIrqTc = 1'b0;
          end
        end
      end
      SER_START, SER_DATA, SER_PAR, SER_STOP: begin
        if (tick) begin
          s_d.txTick = s_q.txTick + 4'h1;
          if (s_q.txTick == OVS_LAST) begin
            case (s_q.txState)
              SER_START: begin
                s_d.txBit = 4'h0;
                s_d.txState = SER_DATA;
              end
              SER_DATA: begin
                s_d.txSh = {1'b0, s_q.txSh[8:1]};
                s_d.txBit = s_q.txBit + 4'h1;
                if (s_q.txBit == DATA_LAST) begin
                  s_d.txState = s_q.txPen ? SER_PAR : SER_STOP;
                end
              end
              SER_PAR: begin
                s_d.txState = SER_STOP;
              end
              default: begin
                // Byte done: address marking lasts one byte only.
                s_d.lctl[LC_ADR] = 1'b0;
                s_d.txState = SER_IDLE;
                if (s_q.ier[IE_TCIE] && !s_d.thrFull) begin
                  s_d.txIrq = 1'b1;
                  s_d.txIrqTc = 1'b1;
                end
              end
            endcase
          end
        end
      end
      default: begin
        s_d.txState = SER_IDLE;
      end
    endcase
    s_d.txd = !(s_d.txState == SER_START) &&
      (!(s_d.txState == SER_DATA || s_d.txState == SER_PAR) || s_d.txSh[0]);
    // Receiver: no enable, so it hunts for a start bit whenever it is idle.
    case (s_q.rxState)
      SER_IDLE: begin
        s_d.rxTick = 4'h0;
        if (!s_q.rxS2) begin
          s_d.rxState = SER_START;
        end
      end
      SER_START, SER_DATA, SER_PAR, SER_STOP: begin
        if (tick) begin
          s_d.rxTick = s_q.rxTick + 4'h1;
          if (s_q.rxState == SER_START && s_q.rxTick == OVS_MID) begin
            // A start bit gone high by its middle was a glitch.
            s_d.rxTick = 4'h0;
            s_d.rxBit = 4'h0;
            s_d.rxState = s_q.rxS2 ? SER_IDLE : SER_DATA;
          end else if (s_q.rxState != SER_START &&
                       s_q.rxTick == OVS_LAST) begin
            case (s_q.rxState)
              SER_DATA: begin
                s_d.rxSh = {1'b0, s_q.rxS2, s_q.rxSh[7:1]};
                s_d.rxBit = s_q.rxBit + 4'h1;
                if (s_q.rxBit == DATA_LAST) begin
                  s_d.rxState = s_q.lctl[LC_PAR] ? SER_PAR : SER_STOP;
                end
              end
              SER_PAR: begin
                s_d.rxSh[8] = s_q.rxS2;
                s_d.rxState = SER_STOP;
              end
              default: begin
                s_d.rbr = s_q.rxSh[7:0];
                s_d.oe = s_q.dr || s_d.oe;
                s_d.dr = 1'b1;
                s_d.fe = !s_q.rxS2 || s_d.fe;
                // A set parity bit marks a station address byte.
                s_d.pe = (s_q.lctl[LC_PAR] && s_q.rxSh[8]) || s_d.pe;
                s_d.rxSh[8] = 1'b0;
                s_d.rxState = SER_IDLE;
              end
            endcase
          end
        end
      end
      default: begin
        s_d.rxState = SER_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset gives the minimum divisor and an idle, marking line.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.divLo <= DIV_RESET[7:0];
      s_q.divHi <= DIV_RESET[15:8];
      s_q.txState <= SER_IDLE;
      s_q.rxState <= SER_IDLE;
      s_q.txd <= 1'b1;
      s_q.rxS1 <= 1'b1;
      s_q.rxS2 <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign txd = s_q.txd;
  assign irq = pendAny;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  tie_raise_a: assert property (@(posedge clk) disable iff (reset)
    (wr && hit(addr, OFS_IER) && !s_q.lctl[LC_DLAB] && wdata[IE_TIE] &&
     !s_q.ier[IE_TIE] && !s_q.thrFull) |=> s_q.txIrq && !s_q.txIrqTc)
    else $error("transmit interrupt not raised on enable");
  thr_clear_a: assert property (@(posedge clk) disable iff (reset)
    (wr && hit(addr, OFS_DATA) && !s_q.lctl[LC_DLAB]) |=>
    !s_q.txIrq && s_q.thrFull)
    else $error("holding write left interrupt pending");
  eps_clear_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.txState == SER_STOP && tick && s_q.txTick == OVS_LAST) |=>
    !s_q.lctl[LC_ADR] && s_q.txState == SER_IDLE)
    else $error("parity select survived byte end");
  bit_time_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.txState == SER_DATA && tick && s_q.txTick != OVS_LAST) |=>
    $stable(s_q.txBit) && $stable(s_q.txd))
    else $error("transmit bit changed early");
  divisor_gate_a: assert property (@(posedge clk) disable iff (reset)
    (wr && !s_q.lctl[LC_DLAB]) |=> !s_q.divLoad && $stable(s_q.divLo))
    else $error("divisor written without access bit");
  addr_mark_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.rxState == SER_STOP && tick && s_q.rxTick == OVS_LAST &&
     s_q.lctl[LC_PAR] && s_q.rxSh[8] && s_q.ier[IE_LSIE] && !wr) |=>
    irq && cause == CAUSE_LS)
    else $error("address mark gave no line status cause");
  rx_hunt_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.rxState == SER_IDLE && !s_q.rxS2) |=> s_q.rxState == SER_START)
    else $error("receiver missed start edge");
endmodule
`default_nettype wire

// ===== rtl/ubg_pkg.sv
// Shared constants for the serial port with its baud tick generator.
package ubg_pkg;
  // ----------------------------------------------------------------------
  // Register offsets relative to the port base address
  // ----------------------------------------------------------------------
  localparam logic [7:0] UBG_BASE0 = 8'hc0;
  localparam logic [7:0] UBG_BASE1 = 8'hd0;
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_IER = 4'h1;
  localparam logic [3:0] OFS_IIR = 4'h2;
  localparam logic [3:0] OFS_LCTL = 4'h3;
  localparam logic [3:0] OFS_LSR = 4'h5;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int LC_PAR = 3;
  localparam int LC_ADR = 4;
  localparam int LC_DLAB = 7;
  localparam int IE_RIE = 0;
  localparam int IE_TIE = 1;
  localparam int IE_LSIE = 2;
  localparam int IE_TCIE = 4;
  localparam int LS_DR = 0;
  localparam int LS_OE = 1;
  localparam int LS_PE = 2;
  localparam int LS_FE = 3;
  localparam int LS_HOLD = 5;
  localparam int LS_TXIDLE = 6;
  // ----------------------------------------------------------------------
  // Reset values, masks and interrupt cause codes
  // ----------------------------------------------------------------------
  localparam logic [15:0] DIV_RESET = 16'h0002;
  localparam logic [15:0] CNT_LAST = 16'h0001;
  localparam logic [7:0] IER_MASK = 8'h17;
  localparam logic [2:0] CAUSE_LS = 3'h3;
  localparam logic [2:0] CAUSE_RX = 3'h2;
  localparam logic [2:0] CAUSE_HOLDING_EMPTY = 3'h1;
  localparam logic [2:0] CAUSE_TC = 3'h5;
  // ----------------------------------------------------------------------
  // Frame figures: ticks per bit, start-bit midpoint, data bits; serial states
  // ----------------------------------------------------------------------
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] DATA_LAST = 4'h7;
  typedef enum logic [4:0] {
    SER_IDLE = 5'h01,
    SER_START = 5'h02,
    SER_DATA = 5'h04,
    SER_PAR = 5'h08,
    SER_STOP = 5'h10
  } ubg_ser_e;
endpackage

// ===== rtl/ubg_baud_tick.sv
// Reloading 16-bit down-counter that makes the 16x oversampling tick.
`timescale 1ns/1ps
`default_nettype none
module ubg_baud_tick
  import ubg_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] divisor,
  input wire logic load,
  output logic tick
);
  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } ubg_cnt_s;
  ubg_cnt_s s_q, s_d;

  // Count down to one, then reload and pulse; a load restarts the count.
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (load) begin
      s_d.count = divisor;
    end else if (s_q.count == CNT_LAST) begin
      s_d.count = divisor;
      s_d.tick = 1'b1;
    end else begin
      s_d.count = s_q.count - 16'h0001;
    end
  end

  // Register the state; the counter starts at the minimum divisor.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '{count: DIV_RESET, tick: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

  pulse_width_a: assert property (@(posedge clk) disable iff (reset)
    tick |=> !tick) else $error("tick longer than a cycle");
  reload_tick_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.count == CNT_LAST && !load) |=> tick && s_q.count == $past(divisor))
    else $error("no reload after count of one");
  count_down_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.count > CNT_LAST && !load) |=> s_q.count == $past(s_q.count) - 1)
    else $error("counter did not decrement");
  load_restart_a: assert property (@(posedge clk) disable iff (reset)
    load |=> !tick && s_q.count == $past(divisor))
    else $error("load did not restart count");
endmodule
`default_nettype wire

// ===== tb/ubg_peer.sv
// Far-end serial station that feeds rxd and captures frames from txd.
`timescale 1ns/1ps
`default_nettype none
module ubg_peer (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  // --------------------------------------------------------------------
  // Line driver
  // --------------------------------------------------------------------
  // The line rests at the mark level between frames, as a real peer does.
  initial begin
    rxd = 1'b1;
  end

  // Start, eight data bits LSB first, parity mark, one stop bit.
  task automatic send(input logic [7:0] b, input logic par,
                      input int bitClks);
    logic [10:0] bits;
    bits = {1'b1, par, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      rxd <= bits[i];
      repeat (bitClks - 1) @(posedge clk);
    end
    @(posedge clk);
  endtask

  // --------------------------------------------------------------------
  // Line monitor
  // --------------------------------------------------------------------
  // Measures the start bit, so callers send bytes whose first bit is one.
  // Sampling on the falling clock edge keeps clear of txd updates.
  task automatic recv(input int bitClks, output logic [7:0] b,
                      output logic p, output int lowClks);
    int t;
    t = 0;
    lowClks = 0;
    b = 8'h00;
    p = 1'b0;
    while (txd !== 1'b0 && t < 4000) begin
      @(negedge clk);
      t++;
    end
    while (txd === 1'b0 && lowClks < 4000) begin
      @(negedge clk);
      lowClks++;
    end
    repeat (bitClks / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = txd;
      repeat (bitClks) @(negedge clk);
    end
    p = txd;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the serial port and its baud tick generator.
`timescale 1ns/1ps
`default_nettype none
module tb
  import ubg_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  wire logic rxd;
  logic txd;
  logic irq;
  int errors = 0;
  int samples_checked = 0;
  logic [7:0] v;
  logic [7:0] rb;
  logic rp;
  int low;

  // --------------------------------------------------------------------
  // Clock, design and far-end station
  // --------------------------------------------------------------------
  // Divisor 3 is used below, so one serial bit lasts 48 clocks.
  always #20 clk = ~clk;

  ubg_uart #(.BASE_ADDR(UBG_BASE0)) ubg_uart_i (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd), .irq(irq)
  );

  ubg_peer ubg_peer_i (.clk(clk), .txd(txd), .rxd(rxd));

  // --------------------------------------------------------------------
  // Reporting and bus tasks
  // --------------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] ofs, input logic [7:0] d);
    @(posedge clk);
    addr <= UBG_BASE0 + {4'h0, ofs};
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd_reg(input logic [3:0] ofs, output logic [7:0] d);
    @(posedge clk);
    addr <= UBG_BASE0 + {4'h0, ofs};
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic rd_chk(input logic [3:0] ofs, input logic [7:0] exp);
    rd_reg(ofs, v);
    chk({8'h00, v}, {8'h00, exp});
  endtask

  // Polls transmitter empty with a bound, so a stuck transmitter ends run.
  task automatic wait_idle();
    int n;
    n = 0;
    v = 8'h00;
    while (v[LS_TXIDLE] !== 1'b1) begin
      rd_reg(OFS_LSR, v);
      n++;
      if (n > 2000) begin
        errors++;
        end_sim();
      end
    end
  endtask

  task automatic rx_case(input logic [7:0] b, input logic par,
                         input logic [7:0] iir, input logic [7:0] lsr);
    ubg_peer_i.send(b, par, 48);
    repeat (4) @(negedge clk);
    chk({15'h0000, irq}, 16'h0001);
    rd_chk(OFS_IIR, iir);
    rd_chk(OFS_LSR, lsr);
    rd_chk(OFS_DATA, b);
    rd_chk(OFS_LSR, 8'h60);
    chk({15'h0000, irq}, 16'h0000);
    $display("receive test done");
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd_chk(OFS_LCTL, 8'h00);
    rd_chk(OFS_IER, 8'h00);
    wr_reg(OFS_LCTL, 8'h80);
    rd_chk(OFS_DATA, 8'h02);
    rd_chk(OFS_IER, 8'h00);
    rd_chk(4'hf, 8'h00);
    wr_reg(OFS_DATA, 8'h03);
    rd_chk(OFS_DATA, 8'h03);
    wr_reg(OFS_LCTL, 8'h08);
    rd_chk(OFS_IER, 8'h00);
    rd_chk(OFS_IIR, 8'h01);
    $display("register test done");
    // Address byte then a data byte queued behind it in the holding slot.
    wr_reg(OFS_IER, 8'h02);
    repeat (2) @(negedge clk);
    chk({15'h0000, irq}, 16'h0001);
    rd_chk(OFS_IIR, 8'h02);
    wr_reg(OFS_LCTL, 8'h18);
    fork
      begin
        wr_reg(OFS_DATA, 8'ha5);
        repeat (8) @(negedge clk);
        wr_reg(OFS_DATA, 8'hc3);
        repeat (4) @(negedge clk);
        chk({15'h0000, irq}, 16'h0000);
      end
      begin
        ubg_peer_i.recv(48, rb, rp, low);
        chk({8'h00, rb}, 16'h00a5);
        chk({15'h0000, rp}, 16'h0001);
        chk(low[15:0], 16'h0030);
        ubg_peer_i.recv(48, rb, rp, low);
        chk({8'h00, rb}, 16'h00c3);
      end
    join
    wait_idle();
    rd_chk(OFS_LCTL, 8'h08);
    // Parity select set while a data byte is still on the line.
    fork
      begin
        wr_reg(OFS_DATA, 8'h39);
        repeat (40) @(negedge clk);
        wr_reg(OFS_LCTL, 8'h18);
      end
      begin
        ubg_peer_i.recv(48, rb, rp, low);
        chk({8'h00, rb}, 16'h0039);
        chk({15'h0000, rp}, 16'h0000);
      end
    join
    wait_idle();
    rd_chk(OFS_LCTL, 8'h08);
    $display("transmit test done");
    wr_reg(OFS_IER, 8'h05);
    rx_case(8'hc3, 1'b1, 8'h06, 8'h65);
    rx_case(8'h5a, 1'b0, 8'h04, 8'h61);
    end_sim();
  end
endmodule
`default_nettype wire
